// File: hw/odc_cfg.svh
// Constants of the operating definition change block.
`ifndef ODC_CFG_SVH
`define ODC_CFG_SVH
`define ODC_OP_CHGDEF 8'h40
`define ODC_OP_COMPARE 8'h39
`define ODC_OP_COPY 8'h18
`define ODC_OP_COPYVER 8'h3a
`define ODC_OP_INQUIRY 8'h12
`define ODC_OP_REQSNS 8'h03
`define ODC_OP_TUR 8'h00
`define ODC_B_LUN 8'h01
`define ODC_B_SAVE 8'h02
`define ODC_B_DEFP 8'h03
`define ODC_B_LEN 8'h08
`define ODC_B_LAST 8'h09
`define ODC_DP_KEEP 7'h00
`define ODC_DP_SCSI1 7'h01
`define ODC_DP_LEGACY 7'h02
`define ODC_DP_SCSI2 7'h03
`define ODC_DP_VEND_LO 7'h40
`define ODC_SC_LU_INI 2'h0
`define ODC_SC_TGT_INI 2'h1
`define ODC_SC_LU_ALL 2'h2
`define ODC_A_CTRL 8'h00
`define ODC_A_STAT 8'h04
`define ODC_A_UA_LO 8'h08
`define ODC_A_UA_HI 8'h0c
`define ODC_F_SCOPE 0
`define ODC_F_PWEN 3
`define ODC_F_KEY 8
`define ODC_F_VCODE 16
`define ODC_F_VEN 23
`define ODC_CTRL_RST 32'h0000_0000
`define ODC_DEF_LVL 3'h3
`define ODC_SENSE0_LEGACY 8'h04
`define ODC_SENSE0_FULL 8'h00
`define ODC_VER_OLD 3'h1
`define ODC_VER_NEW 3'h2
`define ODC_RFMT_SCSI1 4'h0
`define ODC_RFMT_LEGACY 4'h1
`define ODC_RFMT_SCSI2 4'h2
`endif

// File: hw/odc_pkg.sv
// Types shared by the operating definition change block.
package odc_pkg;
    typedef enum logic [3:0] {ST_IDLE = 4'b0001, ST_CDB = 4'b0010, ST_DATA = 4'b0100,
        ST_DONE = 4'b1000} odc_state_t;
    typedef enum logic [2:0] {LV_SCSI1 = 3'h1, LV_LEGACY = 3'h2, LV_SCSI2 = 3'h3,
        LV_VEND = 3'h4} odc_lvl_t;
    typedef enum logic [3:0] {OP_OTHER = 4'h0, OP_CHGDEF = 4'h1, OP_COMPARE = 4'h2,
        OP_COPY = 4'h3, OP_COPYVER = 4'h4, OP_INQ = 4'h5, OP_REQSNS = 4'h6,
        OP_TUR = 4'h7} odc_op_t;
    typedef struct packed {
        logic [2:0] lun;
        logic save;
        logic [6:0] defp;
        logic [7:0] len;
    } odc_cdb_t;
    typedef struct packed {
        logic aen_en;
        logic irec_en;
        logic [7:0] sense0_len;
        logic [2:0] inq_ver;
        logic [3:0] inq_rfmt;
        logic inq_feat_en;
    } odc_beh_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } odc_wbreq_t;
endpackage

// File: hw/odc_top.sv
// Operating definition change command handler with its Wishbone registers.
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "odc_cfg.svh"
module odc_top (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Wishbone slave.
    input odc_pkg::odc_wbreq_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Command bytes and message events from the bus logic.
    input wire logic cdb_valid,
    input wire logic [7:0] cdb_byte,
    input wire logic [2:0] cmd_init,
    input wire logic par_valid,
    input wire logic [7:0] par_byte,
    input wire logic cc_ack_seen,
    input wire logic cmd_fail,
    input wire logic restore_fail,
    // Unit attention clear from the initiator side.
    input wire logic ua_clr,
    input wire logic [5:0] ua_clr_idx,
    // Non-volatile store.
    input wire logic nvm_ok,
    input wire logic [2:0] nvm_lvl,
    output logic nvm_we,
    output logic [2:0] nvm_lvl_o,
    // Results.
    output odc_pkg::odc_op_t op_class,
    output logic data_req,
    output logic chk_cond,
    output odc_pkg::odc_lvl_t cur_lvl,
    output odc_pkg::odc_beh_t beh,
    output logic ua_pend
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    odc_pkg::odc_state_t st_ff, nxt_st;
    odc_pkg::odc_cdb_t cdb_ff, nxt_cdb;
    odc_pkg::odc_op_t op_ff, nxt_op;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [31:0] ctrl_ff, nxt_ctrl, rd_ff, nxt_rd;
    logic chk_ff, nxt_chk, ack_ff, nxt_ack, nvm_we_ff, nxt_nvm_we, ua_pend_ff, nxt_ua_pend;
    logic boot_ff, cmt, ok_end, bad_dp, wr_go;
    logic [63:0][2:0] tbl_ff;
    wire [63:0][2:0] nxt_tbl;
    logic [63:0] ua_ff;
    wire [63:0] nxt_ua;
    logic [2:0] nvm_lvl_ff, nxt_nvm_lvl, new_lvl;
    odc_pkg::odc_lvl_t lvl_ff, nxt_lvl;
    odc_pkg::odc_beh_t beh_ff, nxt_beh;
    logic [5:0] cur_idx;
    logic [1:0] scope;
    assign scope = ctrl_ff[`ODC_F_SCOPE +: 2];
    assign wr_go = wb_req.cyc & wb_req.stb & wb_req.we & ~ack_ff;

    // Maps a unit and initiator to the table entry of the chosen scope.
    function automatic logic [5:0] map_idx(input logic [1:0] sc, input logic [2:0] lu,
        input logic [2:0] ini);
        case (sc)
            `ODC_SC_LU_INI: map_idx = {lu, ini};
            `ODC_SC_TGT_INI: map_idx = {3'h0, ini};
            `ODC_SC_LU_ALL: map_idx = {lu, 3'h0};
            default: map_idx = 6'h00;
        endcase
    endfunction

    // Classifies the first command byte.
    function automatic odc_pkg::odc_op_t dec_op(input logic [7:0] b);
        case (b)
            `ODC_OP_CHGDEF: dec_op = odc_pkg::OP_CHGDEF;
            `ODC_OP_COMPARE: dec_op = odc_pkg::OP_COMPARE;
            `ODC_OP_COPY: dec_op = odc_pkg::OP_COPY;
            `ODC_OP_COPYVER: dec_op = odc_pkg::OP_COPYVER;
            `ODC_OP_INQUIRY: dec_op = odc_pkg::OP_INQ;
            `ODC_OP_REQSNS: dec_op = odc_pkg::OP_REQSNS;
            `ODC_OP_TUR: dec_op = odc_pkg::OP_TUR;
            default: dec_op = odc_pkg::OP_OTHER;
        endcase
    endfunction

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    // Translates the definition parameter and flags values the target refuses.
    always_comb
    begin
        new_lvl = 3'h0;
        bad_dp = 1'b0;
        case (cdb_ff.defp)
            `ODC_DP_KEEP: new_lvl = 3'h0;
            `ODC_DP_SCSI1: new_lvl = odc_pkg::LV_SCSI1;
            `ODC_DP_LEGACY: new_lvl = odc_pkg::LV_LEGACY;
            `ODC_DP_SCSI2: new_lvl = odc_pkg::LV_SCSI2;
            default:
            begin
                new_lvl = odc_pkg::LV_VEND;
                bad_dp = (cdb_ff.defp < `ODC_DP_VEND_LO) | ~ctrl_ff[`ODC_F_VEN]
                    | (cdb_ff.defp != ctrl_ff[`ODC_F_VCODE +: 7]);
            end
        endcase
    end

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    // Collects the command block, counts parameter data and waits for completion.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cdb = cdb_ff;
        nxt_op = op_ff;
        nxt_cnt = cnt_ff;
        nxt_chk = chk_ff;
        ok_end = 1'b0;
        case (st_ff)
            odc_pkg::ST_IDLE:
            begin
                if (cdb_valid)
                begin
                    nxt_op = dec_op(cdb_byte);
                    nxt_cnt = 8'h01;
                    nxt_chk = 1'b0;
                    if (cdb_byte == `ODC_OP_CHGDEF)
                        nxt_st = odc_pkg::ST_CDB;
                end
            end
            odc_pkg::ST_CDB:
            begin
                if (cdb_valid)
                begin
                    case (cnt_ff)
                        `ODC_B_LUN: nxt_cdb.lun = cdb_byte[7:5];
                        `ODC_B_SAVE: nxt_cdb.save = cdb_byte[0];
                        `ODC_B_DEFP: nxt_cdb.defp = cdb_byte[6:0];
                        `ODC_B_LEN: nxt_cdb.len = cdb_byte;
                        default: nxt_cnt = cnt_ff;
                    endcase
                    nxt_cnt = cnt_ff + 8'h01;
                    if (cnt_ff == `ODC_B_LAST)
                    begin
                        nxt_chk = bad_dp;
                        nxt_cnt = 8'h00;
                        nxt_st = (!bad_dp && cdb_ff.len != 8'h00) ? odc_pkg::ST_DATA : odc_pkg::ST_DONE;
                    end
                end
            end
            odc_pkg::ST_DATA:
            begin
                if (par_valid)
                begin
                    if (cnt_ff == 8'h00 && ctrl_ff[`ODC_F_PWEN] && par_byte != ctrl_ff[`ODC_F_KEY +: 8])
                        nxt_chk = 1'b1;
                    nxt_cnt = cnt_ff + 8'h01;
                    if (nxt_cnt == cdb_ff.len)
                        nxt_st = odc_pkg::ST_DONE;
                end
            end
            odc_pkg::ST_DONE:
            begin
                if (cc_ack_seen)
                begin
                    ok_end = ~chk_ff;
                    nxt_st = odc_pkg::ST_IDLE;
                end
            end
            default: nxt_st = odc_pkg::ST_IDLE;
        endcase
        if (cmd_fail)
        begin
            nxt_st = odc_pkg::ST_IDLE;
            ok_end = 1'b0;
        end
    end

    assign cmt = ok_end & (cdb_ff.defp != `ODC_DP_KEEP);
    // Registers the sequencer.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            st_ff <= odc_pkg::ST_IDLE;
            cdb_ff <= '0;
            op_ff <= odc_pkg::OP_OTHER;
            cnt_ff <= 8'h00;
            chk_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            cdb_ff <= nxt_cdb;
            op_ff <= nxt_op;
            cnt_ff <= nxt_cnt;
            chk_ff <= nxt_chk;
        end
    end

    // ----------------------------------------
    // Definition table and unit attention
    // ----------------------------------------
    assign cur_idx = map_idx(scope, cdb_ff.lun, cmd_init);
    // Per entry: boot load, committed change, attention set and clear.
    genvar k;
    generate
        for (k = 0; k < 64; k = k + 1)
        begin : g_ent
            logic aff;
            logic clr;
            assign aff = map_idx(scope, 3'(k >> 3), 3'(k)) == cur_idx;
            assign nxt_tbl[k] = boot_ff ? (nvm_ok ? nvm_lvl : `ODC_DEF_LVL)
                : ((cmt && cur_idx == 6'(k)) ? new_lvl : tbl_ff[k]);
            assign clr = (ua_clr && ua_clr_idx == 6'(k))
                || (wr_go && wb_req.adr == (k < 32 ? `ODC_A_UA_LO : `ODC_A_UA_HI) && wb_req.dat[k % 32]);
            assign nxt_ua[k] = ((cmt | restore_fail) & aff) | (ua_ff[k] & ~clr);
        end
    endgenerate
    // Registers the table; entries start at the default and load once after reset.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            boot_ff <= 1'b1;
            tbl_ff <= {64{`ODC_DEF_LVL}};
            ua_ff <= 64'h0;
        end
        else
        begin
            boot_ff <= 1'b0;
            tbl_ff <= nxt_tbl;
            ua_ff <= nxt_ua;
        end
    end
    // ----------------------------------------
    // Behaviour outputs
    // ----------------------------------------
    // Derives legacy behaviour and the save strobe from the active definition.
    always_comb
    begin
        nxt_lvl = odc_pkg::odc_lvl_t'(tbl_ff[cur_idx]);
        nxt_ua_pend = ua_ff[{cdb_ff.lun, cmd_init}];
        // table consulted, old modes lose both
        nxt_beh.aen_en = nxt_lvl == odc_pkg::LV_SCSI2 || nxt_lvl == odc_pkg::LV_VEND;
        nxt_beh.irec_en = nxt_beh.aen_en;
        nxt_beh.sense0_len = nxt_beh.aen_en ? `ODC_SENSE0_FULL : `ODC_SENSE0_LEGACY;
        nxt_beh.inq_ver = nxt_beh.aen_en ? `ODC_VER_NEW : `ODC_VER_OLD;
        nxt_beh.inq_rfmt = nxt_lvl == odc_pkg::LV_SCSI1 ? `ODC_RFMT_SCSI1
            : (nxt_lvl == odc_pkg::LV_LEGACY ? `ODC_RFMT_LEGACY : `ODC_RFMT_SCSI2);
        nxt_beh.inq_feat_en = nxt_beh.aen_en;
        nxt_nvm_we = ok_end & cdb_ff.save & nvm_ok;
        nxt_nvm_lvl = cmt ? new_lvl : tbl_ff[cur_idx];
    end

    // Registers the behaviour outputs.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            lvl_ff <= odc_pkg::odc_lvl_t'(`ODC_DEF_LVL);
            beh_ff <= '0;
            ua_pend_ff <= 1'b0;
            nvm_we_ff <= 1'b0;
            nvm_lvl_ff <= 3'h0;
        end
        else
        begin
            lvl_ff <= nxt_lvl;
            beh_ff <= nxt_beh;
            ua_pend_ff <= nxt_ua_pend;
            nvm_we_ff <= nxt_nvm_we;
            nvm_lvl_ff <= nxt_nvm_lvl;
        end
    end

    // ----------------------------------------
    // Wishbone registers
    // ----------------------------------------
    // Acks one cycle after the strobe, writes control by byte lanes, muxes reads.
    always_comb
    begin
        nxt_ack = wb_req.cyc & wb_req.stb & ~ack_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rd = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            if (wr_go && wb_req.adr == `ODC_A_CTRL && wb_req.sel[i])
                nxt_ctrl[i * 8 +: 8] = wb_req.dat[i * 8 +: 8];
        end
        case (wb_req.adr)
            `ODC_A_CTRL: nxt_rd = ctrl_ff;
            `ODC_A_STAT: nxt_rd = {19'h0_0000, op_ff, st_ff, chk_ff, lvl_ff, cdb_ff.save};
            `ODC_A_UA_LO: nxt_rd = ua_ff[31:0];
            `ODC_A_UA_HI: nxt_rd = ua_ff[63:32];
            default: nxt_rd = 32'h0000_0000;
        endcase
    end

    // Registers the bus slave.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ack_ff <= 1'b0;
            ctrl_ff <= `ODC_CTRL_RST;
            rd_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= nxt_ack;
            ctrl_ff <= nxt_ctrl;
            rd_ff <= nxt_rd;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rd_ff;
    assign op_class = op_ff;
    assign data_req = st_ff[2]; // The one-hot data state bit itself.
    assign chk_cond = chk_ff;
    assign cur_lvl = lvl_ff;
    assign beh = beh_ff;
    assign ua_pend = ua_pend_ff;
    assign nvm_we = nvm_we_ff;
    assign nvm_lvl_o = nvm_lvl_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    property p_op_decode;
        st_ff == odc_pkg::ST_IDLE && cdb_valid && cdb_byte == `ODC_OP_CHGDEF && !cmd_fail
            |=> op_ff == odc_pkg::OP_CHGDEF && st_ff == odc_pkg::ST_CDB;
    endproperty
    a_op_decode: assert property (p_op_decode) else $error("opcode not decoded");
    property p_nosave;
        ok_end && !cdb_ff.save |=> !nvm_we;
    endproperty
    a_nosave: assert property (p_nosave) else $error("stored without save");
    property p_save;
        ok_end && cdb_ff.save && nvm_ok |=> nvm_we;
    endproperty
    a_save: assert property (p_save) else $error("save missed");
    property p_len0;
        st_ff == odc_pkg::ST_CDB && cdb_valid && cnt_ff == `ODC_B_LAST && cdb_ff.len == 8'h00
            |=> !data_req;
    endproperty
    a_len0: assert property (p_len0) else $error("data phase for zero length");
    property p_hold;
        !boot_ff && !cmt |=> $stable(tbl_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("definition changed early");
    property p_commit;
        cmt |-> st_ff == odc_pkg::ST_DONE && cc_ack_seen && !chk_ff && !cmd_fail;
    endproperty
    a_commit: assert property (p_commit) else $error("commit without completion");
    property p_ua_set;
        cmt |=> ua_ff[$past(cur_idx)];
    endproperty
    a_ua_set: assert property (p_ua_set) else $error("no unit attention");
    property p_ua_keep;
        !ua_clr && !wr_go |=> (ua_ff & $past(ua_ff)) == $past(ua_ff);
    endproperty
    a_ua_keep: assert property (p_ua_keep) else $error("attention lost");
    property p_old_mode;
        cur_lvl == odc_pkg::LV_LEGACY || cur_lvl == odc_pkg::LV_SCSI1
            |-> !beh.aen_en && !beh.irec_en && beh.sense0_len == 8'h04 && !beh.inq_feat_en;
    endproperty
    a_old_mode: assert property (p_old_mode) else $error("legacy behaviour wrong");
    property p_bad;
        st_ff == odc_pkg::ST_CDB && cdb_valid && cnt_ff == `ODC_B_LAST && bad_dp && !cmd_fail
            |=> chk_cond ##1 !cmt [*2];
    endproperty
    a_bad: assert property (p_bad) else $error("bad parameter accepted");
    c_commit: cover property (cmt);
    c_data: cover property (data_req ##1 st_ff == odc_pkg::ST_DONE);
    c_fail: cover property (st_ff == odc_pkg::ST_DONE && cmd_fail);
endmodule

// File: testbench/odc_ini_model.sv
// Behavioural initiator that feeds command, parameter and message events to the target.
`timescale 1ns/1ns
module odc_ini_model (
    // Clock.
    input wire logic mclk,
    // Target status.
    input wire logic data_req,
    // Bus events toward the target.
    output logic cdb_valid,
    output logic [7:0] cdb_byte,
    output logic par_valid,
    output logic [7:0] par_byte,
    output logic cc_ack_seen
);
    // Idle levels at time zero.
    initial
    begin
        cdb_valid = 1'b0;
        cdb_byte = 8'h00;
        par_valid = 1'b0;
        par_byte = 8'h00;
        cc_ack_seen = 1'b0;
    end

    // ten byte block
    // Sends the first n command bytes; a released byte line shows its inverse.
    task automatic send_cmd(input logic [79:0] cdb, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            cdb_valid <= 1'b1;
            cdb_byte <= cdb[79 - 8 * i -: 8];
            @(posedge mclk);
            cdb_valid <= 1'b0;
            cdb_byte <= ~cdb[79 - 8 * i -: 8];
        end
    endtask

    // length counted bytes
    // Sends up to n parameter bytes of value b while the target asks for them.
    task automatic send_par(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            par_valid <= data_req;
            par_byte <= b;
            @(posedge mclk);
            par_valid <= 1'b0;
            par_byte <= ~b;
        end
    endtask

    // completion acknowledge
    // Reports the ACK for the final message byte as a one cycle pulse.
    task automatic complete();
        @(posedge mclk);
        cc_ack_seen <= 1'b1;
        @(posedge mclk);
        cc_ack_seen <= 1'b0;
    endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking testbench for the operating definition change block.
`timescale 1ns/1ns
`include "odc_cfg.svh"
module tb_top;
    logic mclk, nrst, wb_ack_o, cdb_valid, par_valid, cc_ack_seen, cmd_fail, restore_fail;
    logic ua_clr, nvm_ok, nvm_we, data_req, chk_cond, ua_pend;
    logic [31:0] wb_dat_o, rd;
    logic [7:0] cdb_byte, par_byte;
    logic [2:0] cmd_init, nvm_lvl, nvm_lvl_o;
    logic [5:0] ua_clr_idx;
    odc_pkg::odc_wbreq_t wb_req;
    odc_pkg::odc_op_t op_class;
    odc_pkg::odc_lvl_t cur_lvl;
    odc_pkg::odc_beh_t beh;
    int n_mismatch = 0;
    int checked = 0;

    // Block under test and its initiator.
    odc_top u_dut (.mclk(mclk), .nrst(nrst), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cdb_valid(cdb_valid), .cdb_byte(cdb_byte), .cmd_init(cmd_init), .par_valid(par_valid),
        .par_byte(par_byte), .cc_ack_seen(cc_ack_seen), .cmd_fail(cmd_fail), .restore_fail(restore_fail),
        .ua_clr(ua_clr), .ua_clr_idx(ua_clr_idx), .nvm_ok(nvm_ok), .nvm_lvl(nvm_lvl), .nvm_we(nvm_we),
        .nvm_lvl_o(nvm_lvl_o), .op_class(op_class), .data_req(data_req), .chk_cond(chk_cond),
        .cur_lvl(cur_lvl), .beh(beh), .ua_pend(ua_pend));
    odc_ini_model u_ini (.mclk(mclk), .data_req(data_req), .cdb_valid(cdb_valid), .cdb_byte(cdb_byte),
        .par_valid(par_valid), .par_byte(par_byte), .cc_ack_seen(cc_ack_seen));

    // Free running clock.
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Compares and counts.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t value %h, expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle; read data lands in rd at the ack edge.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge mclk);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        // A missing ack ends the run through the common verdict.
        if (n == 20)
        begin
            chk(1'b0, 1'b1);
            end_of_test();
        end
        rd = wb_dat_o;
        wb_req <= '0;
    endtask

    // Reset with a given saved level.
    task automatic do_reset(input logic ok, input logic [2:0] lv);
        @(posedge mclk);
        nrst <= 1'b0;
        nvm_ok <= ok;
        nvm_lvl <= lv;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(negedge mclk);
    endtask

    // Sends a definition change for unit 2 and lets it settle.
    task automatic run(input logic sv, input logic [6:0] dp, input logic [7:0] len);
        u_ini.send_cmd({16'h4040, 7'h00, sv, 1'b0, dp, 32'h0, len, 8'h00}, 10);
        repeat (2) @(negedge mclk);
    endtask

    // Completes a command and waits for the level to land.
    task automatic fin();
        u_ini.complete();
        repeat (3) @(negedge mclk);
    endtask

    task automatic t_reset();
        do_reset(1'b1, 3'h1);
        chk(cur_lvl, 3'h1);
        chk(beh.sense0_len, `ODC_SENSE0_LEGACY);
        do_reset(1'b0, 3'h1);
        chk(cur_lvl, `ODC_DEF_LVL);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, `ODC_CTRL_RST);
        $display("reset test done");
    endtask

    task automatic t_opcode();
        logic [7:0] ops [8] = '{8'h39, 8'h18, 8'h3a, 8'h12, 8'h03, 8'h00, 8'h55, 8'h40};
        logic [3:0] cls [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h1};
        for (int i = 0; i < 8; i++)
        begin
            u_ini.send_cmd({ops[i], 72'h0}, 1);
            @(negedge mclk);
            chk(op_class, cls[i]);
        end
        @(posedge mclk);
        cmd_fail <= 1'b1;
        @(posedge mclk);
        cmd_fail <= 1'b0;
        $display("opcode test done");
    endtask

    task automatic t_commit();
        // Saving is implemented from here on; the strap only matters at boot otherwise.
        @(posedge mclk);
        nvm_ok <= 1'b1;
        run(1'b1, 7'h02, 8'h00);
        chk({data_req, chk_cond}, 2'b00);
        chk(cur_lvl, 3'h3);
        u_ini.complete();
        @(negedge mclk);
        chk({nvm_we, nvm_lvl_o}, 4'ha);
        repeat (3) @(negedge mclk);
        chk(cur_lvl, 3'h2);
        chk(beh, {2'b00, 8'h04, `ODC_VER_OLD, `ODC_RFMT_LEGACY, 1'b0});
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0002_0000);
        chk(ua_pend, 1'b1);
        @(posedge mclk);
        ua_clr <= 1'b1;
        ua_clr_idx <= 6'h11;
        @(posedge mclk);
        ua_clr <= 1'b0;
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        u_ini.send_cmd({8'h12, 72'h0}, 1);
        @(negedge mclk);
        chk({op_class, cur_lvl}, {4'h5, 3'h2});
        $display("commit test done");
    endtask

    task automatic t_save0();
        run(1'b0, 7'h01, 8'h00);
        u_ini.complete();
        @(negedge mclk);
        chk(nvm_we, 1'b0);
        repeat (3) @(negedge mclk);
        chk(cur_lvl, 3'h1);
        run(1'b0, 7'h03, 8'h00);
        fin();
        @(negedge mclk);
        chk({cur_lvl, beh.inq_rfmt}, {3'h3, `ODC_RFMT_SCSI2});
        $display("save test done");
    endtask

    task automatic t_reject();
        logic [6:0] bad [3] = '{7'h04, 7'h3f, 7'h41};
        for (int i = 0; i < 3; i++)
        begin
            run(1'b0, bad[i], 8'h01);
            chk({chk_cond, data_req}, 2'b10);
            fin();
            chk(cur_lvl, 3'h3);
        end
        wb(1'b1, 8'h00, 32'h00c1_0000);
        wb(1'b1, 8'h10, 32'hffff_ffff);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00c1_0000);
        run(1'b0, 7'h41, 8'h00);
        fin();
        chk(cur_lvl, 3'h4);
        run(1'b0, 7'h00, 8'h00);
        fin();
        chk(cur_lvl, 3'h4);
        $display("reject test done");
    endtask

    task automatic t_password();
        wb(1'b1, 8'h00, 32'h0000_5a08);
        run(1'b0, 7'h03, 8'h02);
        chk(data_req, 1'b1);
        u_ini.send_par(8'h5a, 2);
        @(negedge mclk);
        chk({data_req, chk_cond}, 2'b00);
        fin();
        chk(cur_lvl, 3'h3);
        run(1'b0, 7'h01, 8'h01);
        u_ini.send_par(8'ha5, 1);
        @(negedge mclk);
        chk(chk_cond, 1'b1);
        fin();
        chk(cur_lvl, 3'h3);
        $display("password test done");
    endtask

    task automatic t_fail();
        wb(1'b1, 8'h00, 32'h3);
        wb(1'b1, 8'h08, 32'hffff_ffff);
        wb(1'b1, 8'h0c, 32'hffff_ffff);
        wb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        run(1'b0, 7'h02, 8'h00);
        @(posedge mclk);
        cmd_fail <= 1'b1;
        @(posedge mclk);
        cmd_fail <= 1'b0;
        fin();
        chk(cur_lvl, 3'h3);
        @(posedge mclk);
        restore_fail <= 1'b1;
        @(posedge mclk);
        restore_fail <= 1'b0;
        wb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'hffff_ffff);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hffff_ffff);
        $display("failure test done");
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        nrst = 1'b0;
        wb_req = '0;
        cmd_init = 3'h1;
        cmd_fail = 1'b0;
        restore_fail = 1'b0;
        ua_clr = 1'b0;
        ua_clr_idx = 6'h00;
        nvm_ok = 1'b0;
        nvm_lvl = 3'h3;
        t_reset();
        t_opcode();
        t_commit();
        t_save0();
        t_reject();
        t_password();
        t_fail();
        end_of_test();
    end

    // Watchdog against a hang.
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        end_of_test();
    end
endmodule
